// *** hw/dpo_pkg.sv ***
// Shared constants and types for the deserializer parallel output controller.
package dpo_pkg;
  localparam int unsigned CLK_PERIOD_NS     = 50;
  localparam int unsigned OUT_CLK_PERIOD_NS = 400;
  localparam int unsigned OUT_CLK_CYCLES    = OUT_CLK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned PHASE_W           = 3;
  localparam logic [2:0]  PH_LAUNCH         = 3'h0;
  localparam logic [2:0]  PH_STROBE         = 3'h4;
  localparam logic [2:0]  PH_STROBE_SPREAD  = 3'h5;
  localparam logic [2:0]  PH_LAST           = 3'(OUT_CLK_CYCLES - 1);

  localparam int unsigned PIX_W   = 24;
  localparam int unsigned GROUP_W = 8;

  localparam int unsigned LFSR_W     = 7;
  localparam logic [6:0]  LFSR_SEED  = 7'h7F;
  localparam int unsigned LFSR_TAP_A = 6;
  localparam int unsigned LFSR_TAP_B = 5;

  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned DATA_W     = 8;
  localparam logic [3:0]  REG_STATUS = 4'h0;
  localparam logic [3:0]  REG_MASK   = 4'h4;
  localparam logic [3:0]  REG_STATE  = 4'h8;
  localparam logic [7:0]  MASK_RST   = 8'h00;
  localparam int unsigned ST_LOCK_GAIN = 0;
  localparam int unsigned ST_LOCK_LOSS = 1;
  localparam int unsigned ST_WORD_DROP = 2;
  localparam int unsigned NUM_EVT      = 3;

  // Configuration pins, all asynchronous to ref_clk.
  typedef struct packed {
    logic edge_sel;
    logic pto_sel;
    logic rand_bypass;
    logic out_en;
    logic sleep_n;
  } dpo_cfg_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dpo_bus_req_t;

  typedef enum logic [1:0] {
    OS_OFF  = 2'b00,
    OS_WAIT = 2'b01,
    OS_RUN  = 2'b10
  } dpo_out_state_t;
endpackage

// *** hw/dpo_ctrl.sv ***
// Parallel output control of a serial-link deserializer: descramble, launch, stagger, enables.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RULE1] Output clock strobe edge follows the edge-select pin.
// [RULE2] Edge-select high strobes on rising output clock, low on falling.
// [RULE3] Lock flag is high while the receiver PLL is locked, low otherwise.
// [RULE4] Data outputs and output clock are tri-stated while unlocked.
// [RULE5] Turn-on select high staggers the three byte groups by one to two cycles.
// [RULE6] Turn-on select low spreads data bits and shifts the output clock by one.
// [RULE7] Randomizer bypass high passes words without extra descrambling.
// [RULE8] Bypass low removes the 7-bit LFSR randomization; serializer must match.
// [RULE9] Output enable high drives data outputs and output clock.
// [RULE10] Output enable low tri-states outputs while the PLL keeps running.
// [RULE11] Sleep input low tri-states data, clock and lock flag and stops the PLL.
// [RULE12] Outputs drive only with lock high and output enable high.
module dpo_ctrl (
  input  wire logic                       ref_clk,            // 20 MHz clock
  input  wire logic                       rst_n,              // Asynchronous reset
  input  wire dpo_pkg::dpo_bus_req_t      bus_req,            // Register request
  output var  logic [dpo_pkg::DATA_W-1:0] bus_rdata,          // Read data, one cycle later
  output var  logic                       irq,                // Level interrupt
  input  wire dpo_pkg::dpo_cfg_t          cfg_pins,           // Raw configuration pins
  input  wire logic                       pll_lock_raw,       // Raw PLL lock detector
  input  wire logic [dpo_pkg::PIX_W-1:0]  rx_word,            // Received word from front end
  input  wire logic                       rx_word_valid,      // One-cycle word strobe
  output var  logic                       pll_enable,         // PLL power
  output var  logic [dpo_pkg::PIX_W-1:0]  parallel_data_out,  // Parallel data
  output var  logic                       parallel_data_oe,   // Data output enable
  output var  logic                       out_clk,            // Parallel output clock
  output var  logic                       out_clk_oe,         // Output clock enable
  output var  logic                       lock_flag,          // Lock flag level
  output var  logic                       lock_flag_oe        // Lock flag enable
);
  localparam int unsigned SYNC_W = $bits(dpo_pkg::dpo_cfg_t) + 1;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic [SYNC_W-1:0] sync3_q;
  logic [SYNC_W-1:0] stable_q;
  dpo_pkg::dpo_cfg_t cfg_s;
  logic              lock_s;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= {cfg_pins, pll_lock_raw};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // A pin change counts only once the second and third stages agree.
  genvar gs;
  generate
    for (gs = 0; gs < SYNC_W; gs++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          stable_q[gs] <= 1'b0;
        end else if (sync2_q[gs] == sync3_q[gs]) begin
          stable_q[gs] <= sync3_q[gs];
        end
      end
    end
  endgenerate

  assign cfg_s  = dpo_pkg::dpo_cfg_t'(stable_q[SYNC_W-1:1]);
  assign lock_s = stable_q[0];
  logic awake;
  logic locked;
  logic drive;
  logic pto_sel;
  assign awake   = cfg_s.sleep_n;
  assign locked  = awake && lock_s;
  assign drive   = locked && cfg_s.out_en;
  assign pto_sel = cfg_s.pto_sel;
  // ----------------------------------------------------------------
  // Output state and pixel phase
  // ----------------------------------------------------------------
  dpo_pkg::dpo_out_state_t state_q;
  logic [dpo_pkg::PHASE_W-1:0] phase_q;
  logic                        hold_full_q;
  logic                        launch;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dpo_pkg::OS_OFF;
    end else begin
      case (state_q)
        dpo_pkg::OS_OFF:  if (locked) state_q <= dpo_pkg::OS_WAIT;
        dpo_pkg::OS_WAIT: begin
          if (!locked) begin
            state_q <= dpo_pkg::OS_OFF;
          end else if (hold_full_q) begin
            state_q <= dpo_pkg::OS_RUN;
          end
        end
        dpo_pkg::OS_RUN:  if (!locked) state_q <= dpo_pkg::OS_OFF;
        default:          state_q <= dpo_pkg::OS_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= dpo_pkg::PH_LAUNCH;
    end else if (!locked || phase_q == dpo_pkg::PH_LAST) begin
      phase_q <= dpo_pkg::PH_LAUNCH;
    end else begin
      phase_q <= phase_q + 3'h1;
    end
  end

  assign launch = locked && phase_q == dpo_pkg::PH_LAUNCH;
  // ----------------------------------------------------------------
  // Descrambler and word holding register
  // ----------------------------------------------------------------
  function automatic logic [dpo_pkg::PIX_W-1:0] key_of(input logic [dpo_pkg::LFSR_W-1:0] s);
    key_of = {s, s, s, s[2:0]};
  endfunction
  logic [dpo_pkg::LFSR_W-1:0] lfsr_q;
  logic [dpo_pkg::PIX_W-1:0]  keystream;
  logic [dpo_pkg::PIX_W-1:0]  hold_q;
  logic                       word_drop;
  assign keystream = key_of(lfsr_q);
  // The keystream restarts from the seed at every new lock.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= dpo_pkg::LFSR_SEED;
    end else if (!locked) begin
      lfsr_q <= dpo_pkg::LFSR_SEED;
    end else if (rx_word_valid && !cfg_s.rand_bypass) begin
      lfsr_q <= {lfsr_q[dpo_pkg::LFSR_W-2:0],
                 lfsr_q[dpo_pkg::LFSR_TAP_A] ^ lfsr_q[dpo_pkg::LFSR_TAP_B]}; // [RULE8]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (rx_word_valid) begin
      hold_q <= cfg_s.rand_bypass ? rx_word : (rx_word ^ keystream); // [RULE7] [RULE8]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_full_q <= 1'b0;
    end else if (!locked) begin
      hold_full_q <= 1'b0;
    end else if (rx_word_valid) begin
      hold_full_q <= 1'b1;
    end else if (launch) begin
      hold_full_q <= 1'b0;
    end
  end

  assign word_drop = locked && rx_word_valid && hold_full_q && !launch;
  // ----------------------------------------------------------------
  // Launch and staggered output groups
  // ----------------------------------------------------------------
  logic [dpo_pkg::PIX_W-1:0] pix_q;
  logic [dpo_pkg::PIX_W-1:0] tap1_q;
  logic [dpo_pkg::PIX_W-1:0] tap2_q;
  logic [dpo_pkg::PIX_W-1:0] data_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_q  <= '0;
      tap1_q <= '0;
      tap2_q <= '0;
    end else begin
      if (launch && hold_full_q) begin
        pix_q <= hold_q;
      end
      tap1_q <= pix_q;
      tap2_q <= tap1_q;
    end
  end

  // Turn-on mode delays byte group g by g cycles; spread mode delays bit i by i mod 3.
  genvar gb;
  generate
    for (gb = 0; gb < dpo_pkg::PIX_W; gb++) begin : g_bit
      localparam int unsigned GRP = gb / dpo_pkg::GROUP_W;
      localparam int unsigned SPR = gb % 3;
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          data_q[gb] <= 1'b0;
        end else begin
          case (pto_sel ? GRP : SPR)
            0:       data_q[gb] <= pix_q[gb];  // [RULE5] [RULE6]
            1:       data_q[gb] <= tap1_q[gb];
            default: data_q[gb] <= tap2_q[gb];
          endcase
        end
      end
    end
  endgenerate

  assign parallel_data_out = data_q;
  // ----------------------------------------------------------------
  // Output clock
  // ----------------------------------------------------------------
  logic [2:0] strobe_ph;
  logic       clk_active;
  logic       clk_q;
  assign strobe_ph  = pto_sel ? dpo_pkg::PH_STROBE : dpo_pkg::PH_STROBE_SPREAD; // [RULE6]
  assign clk_active = locked && phase_q >= strobe_ph;

  // The strobe edge sits mid-pixel, after the latest staggered group has settled.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= cfg_s.edge_sel ? clk_active : !clk_active; // [RULE1] [RULE2]
    end
  end

  assign out_clk = clk_q;
  // ----------------------------------------------------------------
  // Enables, lock flag and PLL power
  // ----------------------------------------------------------------
  logic drive_q;
  logic lock_q;
  logic lock_oe_q;
  logic pll_en_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= drive; // [RULE4] [RULE9] [RULE10] [RULE12]
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_q    <= 1'b0;
      lock_oe_q <= 1'b0;
      pll_en_q  <= 1'b0;
    end else begin
      lock_q    <= locked; // [RULE3]
      lock_oe_q <= awake;  // [RULE11]
      pll_en_q  <= awake;  // [RULE10] [RULE11]
    end
  end

  assign parallel_data_oe = drive_q;
  assign out_clk_oe       = drive_q;
  assign lock_flag        = lock_q;
  assign lock_flag_oe     = lock_oe_q;
  assign pll_enable       = pll_en_q;
  // ----------------------------------------------------------------
  // Registers and interrupt
  // ----------------------------------------------------------------
  logic                        locked_prev_q;
  logic [dpo_pkg::NUM_EVT-1:0] evt;
  logic [dpo_pkg::NUM_EVT-1:0] status_q;
  logic [dpo_pkg::NUM_EVT-1:0] status_d;
  logic [dpo_pkg::NUM_EVT-1:0] mask_q;
  logic [dpo_pkg::DATA_W-1:0]  rdata_q;
  logic                        irq_q;
  logic                        rd_status;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      locked_prev_q <= 1'b0;
    end else begin
      locked_prev_q <= locked;
    end
  end

  always_comb begin
    evt = '0;
    evt[dpo_pkg::ST_LOCK_GAIN] = locked && !locked_prev_q;
    evt[dpo_pkg::ST_LOCK_LOSS] = !locked && locked_prev_q;
    evt[dpo_pkg::ST_WORD_DROP] = word_drop;
  end

  assign rd_status = bus_req.rd && bus_req.addr == dpo_pkg::REG_STATUS;
  // A read clears the status, but an event in the same cycle survives it.
  always_comb begin
    status_d = rd_status ? evt : (status_q | evt);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= dpo_pkg::MASK_RST[dpo_pkg::NUM_EVT-1:0];
    end else if (bus_req.wr && bus_req.addr == dpo_pkg::REG_MASK) begin
      mask_q <= bus_req.wdata[dpo_pkg::NUM_EVT-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        dpo_pkg::REG_STATUS: rdata_q <= {5'h00, status_q};
        dpo_pkg::REG_MASK:   rdata_q <= {5'h00, mask_q};
        dpo_pkg::REG_STATE:  rdata_q <= {state_q, cfg_s, locked};
        default:             rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_q);
    end
  end

  assign bus_rdata = rdata_q;
  assign irq       = irq_q;
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_lock_flag_high: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
    locked |=> lock_flag) else $error("lock flag low while locked");
  a_lock_flag_low: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
    !locked |=> !lock_flag) else $error("lock flag high while unlocked");
  a_unlock_tristate: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
    !lock_s |=> !parallel_data_oe && !out_clk_oe) else $error("outputs driven while unlocked");
  a_enable_drives: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE9]
    drive |=> parallel_data_oe && out_clk_oe) else $error("outputs not driven when enabled");
  a_disable_pll_on: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE10]
    (awake && !cfg_s.out_en) |=> !parallel_data_oe && pll_enable) else $error("disable misbehaves");
  a_sleep_all_off: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE11]
    !awake |=> !lock_flag_oe && !pll_enable && !out_clk_oe) else $error("sleep not honoured");
  a_drive_needs_lock: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
    parallel_data_oe |-> lock_flag) else $error("driving without lock flag");
  a_rise_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE2]
    (locked && cfg_s.edge_sel && $stable(cfg_s) && phase_q == strobe_ph) |=> $rose(out_clk))
    else $error("no rising strobe edge");
  a_fall_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE1]
    (locked && !cfg_s.edge_sel && $stable(cfg_s) && phase_q == strobe_ph) |=> $fell(out_clk))
    else $error("no falling strobe edge");
  a_group_stagger: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
    $past(pto_sel) |-> parallel_data_out[23:16] == $past(pix_q[23:16], 3))
    else $error("third group not two cycles late");
  a_spread_bits: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE6]
    !$past(pto_sel) |-> parallel_data_out[1] == $past(pix_q[1], 2))
    else $error("spread bit delay wrong");
  a_bypass_word: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
    (rx_word_valid && cfg_s.rand_bypass) |=> hold_q == $past(rx_word))
    else $error("bypass word altered");
  a_descramble_word: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
    (rx_word_valid && !cfg_s.rand_bypass) |=> hold_q == ($past(rx_word) ^ $past(keystream)))
    else $error("descrambled word wrong");
endmodule
`default_nettype wire

// *** verification/dpo_link_model.sv ***
// Behavioural model of the serial front end that feeds the output controller.
`timescale 1ns/100ps
`default_nettype none
module dpo_link_model (
  input  wire logic                      ref_clk,       // Clock
  output var  logic                      pll_lock_raw,  // Far PLL lock level
  output var  logic [dpo_pkg::PIX_W-1:0] rx_word,       // Received word
  output var  logic                      rx_word_valid  // One-cycle word strobe
);
  initial begin
    pll_lock_raw  = 1'b0;
    rx_word       = 24'h000000;
    rx_word_valid = 1'b0;
  end
  // ----------------------------------------------------------------
  // Stream control
  // ----------------------------------------------------------------
  task automatic set_lock(input logic v);
    @(posedge ref_clk);
    pll_lock_raw <= v;
  endtask
  // Words go out unscrambled, as from a serializer without the extra randomization.
  // Afterwards the lines carry the inverse, so stale data never passes for a word.
  task automatic send(input logic [dpo_pkg::PIX_W-1:0] w);
    @(posedge ref_clk);
    rx_word       <= w;
    rx_word_valid <= 1'b1;
    @(posedge ref_clk);
    rx_word       <= ~w;
    rx_word_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verification/test_dpo_ctrl.sv ***
// Self-checking testbench for the parallel output controller.
`timescale 1ns/100ps
`default_nettype none
module test_dpo_ctrl;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic                  ref_clk;
  logic                  rst_n;
  dpo_pkg::dpo_bus_req_t bus_req;
  logic [7:0]            bus_rdata;
  logic                  irq;
  dpo_pkg::dpo_cfg_t     cfg_pins;
  logic                  pll_lock_raw;
  logic [23:0]           rx_word;
  logic                  rx_word_valid;
  logic                  pll_enable;
  logic [23:0]           parallel_data_out;
  logic                  parallel_data_oe;
  logic                  out_clk;
  logic                  out_clk_oe;
  logic                  lock_flag;
  logic                  lock_flag_oe;
  logic [7:0]            v;
  int                    miscompares;
  int                    checks;

  dpo_ctrl i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata), .irq(irq),
    .cfg_pins(cfg_pins), .pll_lock_raw(pll_lock_raw), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
    .pll_enable(pll_enable), .parallel_data_out(parallel_data_out), .parallel_data_oe(parallel_data_oe),
    .out_clk(out_clk), .out_clk_oe(out_clk_oe), .lock_flag(lock_flag), .lock_flag_oe(lock_flag_oe)
  );
  dpo_link_model i_link (
    .ref_clk(ref_clk), .pll_lock_raw(pll_lock_raw), .rx_word(rx_word), .rx_word_valid(rx_word_valid)
  );

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic give_up();
    miscompares++;
    $display("BAD %0t wait ran out", $time);
    finish_test();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    d = bus_rdata;
  endtask
  task automatic wait_data(input logic [23:0] w);
    for (int k = 0; k < 40; k++) begin
      if (parallel_data_out === w) begin
        return;
      end
      idle(1);
    end
    give_up();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_lock_irq();
    chk_bit(lock_flag, 1'b0);
    chk_bit(parallel_data_oe, 1'b0);
    chk_bit(out_clk_oe, 1'b0);
    i_link.set_lock(1'b1);
    idle(8);
    chk_bit(lock_flag, 1'b1);
    chk_bit(parallel_data_oe, 1'b1);
    chk_bit(out_clk_oe, 1'b1);
    chk_bit(irq, 1'b0);
    bus_wr(dpo_pkg::REG_MASK, 8'h07);
    idle(2);
    chk_bit(irq, 1'b1);
    bus_rd(dpo_pkg::REG_STATUS, v);
    chk_val({16'h0000, v}, 24'h000001);
    idle(1);
    chk_bit(irq, 1'b0);
    bus_rd(4'hC, v);
    chk_val({16'h0000, v}, 24'h000000);
    bus_rd(dpo_pkg::REG_MASK, v);
    chk_val({16'h0000, v}, 24'h000007);
  endtask
  task automatic t_bypass();
    i_link.send(24'h5A3CC3);
    wait_data(24'h5A3CC3);
    idle(16);
    chk_val(parallel_data_out, 24'h5A3CC3);
  endtask
  task automatic t_derand();
    logic [23:0] k;
    @(posedge ref_clk);
    cfg_pins.rand_bypass <= 1'b0;
    idle(8);
    // The seed 7F gives an all-ones key, and its successor 7E gives the key FDFBF6.
    i_link.send(24'h123456);
    idle(20);
    chk_val(parallel_data_out, 24'hEDCBA9);
    i_link.send(24'h654321);
    idle(20);
    k = parallel_data_out ^ 24'h654321;
    chk_val(k, 24'hFDFBF6);
    @(posedge ref_clk);
    cfg_pins.rand_bypass <= 1'b1;
    idle(8);
  endtask
  task automatic t_stagger(input logic staggered_output_switching);
    int t[24];
    @(posedge ref_clk);
    cfg_pins.pto_sel <= staggered_output_switching;
    idle(8);
    i_link.send(24'hFFFFFF);
    wait_data(24'hFFFFFF);
    idle(8);
    t = '{default: -1};
    i_link.send(24'h000000);
    for (int c = 0; c < 24; c++) begin
      idle(1);
      for (int i = 0; i < 24; i++) begin
        if (t[i] < 0 && parallel_data_out[i] === 1'b0) begin
          t[i] = c;
        end
      end
    end
    for (int i = 0; i < 24; i++) begin
      chk_val(24'(t[i] - t[0]), staggered_output_switching ? 24'(i / 8) : 24'(i % 3));
    end
  endtask
  task automatic t_edge(input logic e);
    logic p;
    @(posedge ref_clk);
    cfg_pins.edge_sel <= e;
    idle(8);
    i_link.send(e ? 24'h0F0F0F : 24'hF0F0F0);
    wait_data(e ? 24'h0F0F0F : 24'hF0F0F0);
    p = out_clk;
    for (int k = 0; k <= 12; k++) begin
      if (k == 12) begin
        give_up();
      end
      idle(1);
      if (out_clk !== p) begin
        break;
      end
    end
    chk_bit(out_clk, e);
  endtask
  task automatic t_out_en();
    @(posedge ref_clk);
    cfg_pins.out_en <= 1'b0;
    idle(8);
    chk_bit(parallel_data_oe, 1'b0);
    chk_bit(out_clk_oe, 1'b0);
    chk_bit(lock_flag, 1'b1);
    chk_bit(pll_enable, 1'b1);
    @(posedge ref_clk);
    cfg_pins.out_en <= 1'b1;
    idle(8);
    chk_bit(parallel_data_oe, 1'b1);
  endtask
  task automatic t_mid_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    idle(1);
    chk_bit(lock_flag, 1'b0);
    chk_bit(parallel_data_oe, 1'b0);
    chk_val(parallel_data_out, 24'h000000);
    chk_bit(pll_enable, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    idle(8);
    chk_bit(lock_flag, 1'b1);
    chk_bit(out_clk_oe, 1'b1);
    bus_rd(dpo_pkg::REG_STATE, v);
    chk_val({16'h0000, v}, 24'h00004F);
    bus_rd(dpo_pkg::REG_MASK, v);
    chk_val({16'h0000, v}, 24'h000000);
    bus_wr(dpo_pkg::REG_MASK, 8'h07);
    bus_rd(dpo_pkg::REG_STATUS, v);
    chk_val({16'h0000, v}, 24'h000001);
  endtask
  task automatic t_unlock_sleep();
    i_link.set_lock(1'b0);
    idle(8);
    chk_bit(lock_flag, 1'b0);
    chk_bit(parallel_data_oe, 1'b0);
    chk_bit(out_clk_oe, 1'b0);
    chk_bit(irq, 1'b1);
    bus_rd(dpo_pkg::REG_STATUS, v);
    chk_val({16'h0000, v}, 24'h000002);
    i_link.set_lock(1'b1);
    @(posedge ref_clk);
    cfg_pins.sleep_n <= 1'b0;
    idle(8);
    chk_bit(lock_flag_oe, 1'b0);
    chk_bit(pll_enable, 1'b0);
    chk_bit(parallel_data_oe, 1'b0);
    chk_bit(out_clk_oe, 1'b0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (50000) @(posedge ref_clk);
    give_up();
  end
  initial begin
    miscompares = 0;
    checks      = 0;
    rst_n       = 1'b0;
    bus_req     = '0;
    cfg_pins    = '{edge_sel: 1'b1, pto_sel: 1'b1, rand_bypass: 1'b1, out_en: 1'b1, sleep_n: 1'b1};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    idle(8);
    chk_bit(lock_flag_oe, 1'b1);
    t_lock_irq();
    t_bypass();
    t_derand();
    t_stagger(1'b1);
    t_stagger(1'b0);
    t_edge(1'b1);
    t_edge(1'b0);
    t_out_en();
    t_mid_reset();
    t_unlock_sleep();
    finish_test();
  end
endmodule
`default_nettype wire
